// [e3tx_pkg.sv]
// Shared constants, field layout and carriers for the E3 transmit overhead block
package e3tx_pkg;
  // Register bus widths
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  // Register offsets
  localparam logic [ADDR_W-1:0] STAT_OFS = 10'h116;
  localparam logic [ADDR_W-1:0] TFC_OFS = 10'h118;
  localparam logic [ADDR_W-1:0] TEI_OFS = 10'h11A;
  localparam logic [ADDR_W-1:0] TMA_OFS = 10'h11C;
  localparam logic [ADDR_W-1:0] TNG_OFS = 10'h11E;
  // Writable bits per register, reserved bits read zero
  localparam logic [DATA_W-1:0] TFC_MASK = 16'h073F;
  localparam logic [DATA_W-1:0] TEI_MASK = 16'h03FF;
  localparam logic [DATA_W-1:0] TMA_MASK = 16'h00FF;
  localparam logic [DATA_W-1:0] TNG_MASK = 16'hFFFF;
  localparam logic [DATA_W-1:0] REG_RST = 16'h0000;
  // Frame control fields
  localparam int GC_SRC_BIT = 10;
  localparam int NR_SRC_LSB = 8;
  localparam int REI_MAN_BIT = 5;
  localparam int REI_DEF_BIT = 4;
  localparam int RDI_MAN_BIT = 3;
  localparam int RDI_DEF_BIT = 2;
  localparam int FGD_BIT = 1;
  localparam int AIS_BIT = 0;
  // Error insertion fields
  localparam int REI_CONT_BIT = 9;
  localparam int REI_EN_BIT = 8;
  localparam int PAR_BLK_BIT = 7;
  localparam int PAR_CONT_BIT = 6;
  localparam int PAR_EN_BIT = 5;
  localparam int FE_TYPE_LSB = 3;
  localparam int FE_EN_BIT = 2;
  localparam int SE_REQ_BIT = 1;
  localparam int TRIG_SEL_BIT = 0;
  // MA byte field register and NR/GC value register
  localparam int PT_LSB = 5;
  localparam int TIMING_IND_GEN_DISABLE_BIT = 4;
  localparam int TTI_MSB = 3;
  localparam int GC_LSB = 8;
  // Frame geometry: byte positions counted from the first FA1 byte
  localparam int FRAME_LEN = 537;
  localparam logic [9:0] POS_FA1 = 10'h000;
  localparam logic [9:0] POS_FA2 = 10'h001;
  localparam logic [9:0] POS_EM = 10'h03D;
  localparam logic [9:0] POS_MA = 10'h0B5;
  localparam logic [9:0] POS_NR = 10'h0F1;
  localparam logic [9:0] POS_GC = 10'h12D;
  // Overhead byte values and masks
  localparam logic [7:0] FA1_VAL = 8'hF6;
  localparam logic [7:0] FA2_VAL = 8'h28;
  localparam logic [7:0] ALL_ONES = 8'hFF;
  localparam logic [7:0] ONE_BIT = 8'h01;
  localparam logic [7:0] REI_POS = 8'h40;
  localparam logic [2:0] FE_MULTI_LEFT = 3'h3;
  // NR byte sources
  typedef enum logic [1:0] {
    NR_ONES = 2'b00,
    NR_HDLC = 2'b01,
    NR_FEAC = 2'b10,
    NR_REG = 2'b11
  } nr_src_e;
  // Framing error types
  typedef enum logic [1:0] {
    FE_BIT1 = 2'b00,
    FE_WORD1 = 2'b01,
    FE_BIT4 = 2'b10,
    FE_WORD4 = 2'b11
  } fe_type_e;
  // One byte of the stream
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_s;
  // Register write or read request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;
  // Whole state of the overhead block
  typedef struct packed {
    logic [DATA_W-1:0] tfc;
    logic [DATA_W-1:0] tei;
    logic [DATA_W-1:0] tma;
    logic [DATA_W-1:0] tng;
    logic [DATA_W-1:0] s_tfc;
    logic [DATA_W-1:0] s_tei;
    logic [DATA_W-1:0] s_tma;
    logic [DATA_W-1:0] s_tng;
    logic [DATA_W-1:0] rdata;
    logic [9:0] pos;
    logic [1:0] mf;
    logic trig_d;
    logic pend_rei;
    logic pend_par;
    logic pend_fe;
    logic [2:0] fe_left;
    logic fe_word_act;
    logic rei_seen;
    logic [7:0] bip_acc;
    logic [7:0] bip_prev;
    byte_s out;
  } state_s;
endpackage

// [e3tx_sync.sv]
// Two-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
module e3tx_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Asynchronous level in, synchronised level out
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  // Both stages held in one state word
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_s;

  sync_s st_r; // Registered stages
  sync_s st_nxt; // Next stages

  // First stage feeds only the second
  always_comb begin
    st_nxt.s1 = i_async;
    st_nxt.s2 = st_r.s1;
  end

  // Stage registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_sync = st_r.s2;
endmodule

// [e3tx_overhead.sv]
// E3 G.832 transmit overhead generation and error insertion
`timescale 1ns/1ps
// Behaviour
// - GC from HDLC, or GC register value
// - NR source: ones, HDLC, FEAC, register
// - GC and NR each take own HDLC byte
// - Manual REI goes to MA bit two
// - REI automatic from input, or manual
// - Manual RDI goes to MA bit one
// - RDI automatic from receiver alarms, or manual
// - Frame disable passes FA1, FA2, EM and MA bytes through
// - AIS forces whole output to ones
// - REI errors single or continuous when enabled
// - Parity error inverts one or eight bits
// - Parity errors single or continuous when enabled
// - Framing error type: bit/word, one/four frames
// - Framing errors only while enabled
// - Register bit rising edge triggers errors
// - Many toggles per opportunity give one error
// - Trigger select picks the external input
// - Payload type in MA bits three-five
// - Timing bits generated or sent directly
// - GC upper byte, NR lower byte
module e3tx_overhead #(
  parameter int FRAME_BYTES = e3tx_pkg::FRAME_LEN
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register port
  input wire e3tx_pkg::reg_req_s i_reg,
  output logic [e3tx_pkg::DATA_W-1:0] o_rdata,
  // Payload stream in, framed stream out
  input wire e3tx_pkg::byte_s i_pay,
  output e3tx_pkg::byte_s o_line,
  // HDLC and FEAC byte sources
  input wire logic [7:0] i_hdlc_data,
  output logic o_hdlc_take,
  input wire logic [7:0] i_feac_data,
  // Pin-level indications and trigger
  input wire logic i_remote_err_indication_in,
  input wire logic i_rx_alarm,
  input wire logic i_ext_err_trigger_in
);
  // Frame length must fit the position counter and hold every overhead byte
  if (FRAME_BYTES > 1024 || FRAME_BYTES <= int'(e3tx_pkg::POS_GC)) begin : g_len_chk
    $error("FRAME_BYTES out of range");
  end

  localparam logic [9:0] LAST_POS = 10'(FRAME_BYTES - 1); // Final byte index

  e3tx_pkg::state_s st_r; // Registered state
  e3tx_pkg::state_s st_nxt; // Next state
  logic [2:0] pin_s; // Synchronised pin levels
  logic rei_s; // Remote error indication
  logic alarm_s; // Receiver alarm
  logic ext_s; // External trigger

  // Pins cross through two flops before use
  e3tx_sync #(.W(3)) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_remote_err_indication_in, i_rx_alarm, i_ext_err_trigger_in}),
    .o_sync(pin_s)
  );
  assign rei_s = pin_s[2];
  assign alarm_s = pin_s[1];
  assign ext_s = pin_s[0];

  typedef e3tx_pkg::nr_src_e nr_src_sel_t; // NR source code

  // Working values of the combinational process
  logic first; // First byte of a frame
  logic [15:0] c_tfc; // Frame control in force
  logic [15:0] c_tei; // Error control in force
  logic [15:0] c_tma; // MA fields in force
  logic [15:0] c_tng; // NR/GC values in force
  logic trig; // Selected trigger level
  logic edge_up; // Trigger rising edge
  logic rei_en; // REI insertion enabled
  logic par_en; // Parity insertion enabled
  logic fe_en; // Framing insertion enabled
  logic use_rei; // REI error goes into this MA
  logic use_par; // Parity error goes into this EM
  logic use_fe; // Framing error goes into this FA pair
  logic fe_new; // Pending framing error starts here
  logic fe_word; // Word type framing error
  logic rei_bit; // REI bit sent
  logic rdi_bit; // RDI bit sent
  logic [2:0] ti_bits; // Last three MA bits
  logic [7:0] d; // Byte being formed
  logic fgd; // Frame generation disabled
  nr_src_sel_t nr_src; // NR source in force
  logic hdlc_take; // HDLC byte consumed

  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = '0;
    st_nxt.out.valid = 1'b0;
    hdlc_take = 1'b0;
    d = i_pay.data;

    // Register writes, masked to the defined bits
    if (i_reg.wr) begin
      unique case (i_reg.addr)
        e3tx_pkg::TFC_OFS: st_nxt.tfc = i_reg.wdata & e3tx_pkg::TFC_MASK;
        e3tx_pkg::TEI_OFS: st_nxt.tei = i_reg.wdata & e3tx_pkg::TEI_MASK;
        e3tx_pkg::TMA_OFS: st_nxt.tma = i_reg.wdata & e3tx_pkg::TMA_MASK;
        e3tx_pkg::TNG_OFS: st_nxt.tng = i_reg.wdata & e3tx_pkg::TNG_MASK;
        default: begin
          // Unmapped or read-only: ignored
        end
      endcase
    end

    // Register reads, answered the next cycle; unmapped reads zero
    if (i_reg.rd) begin
      unique case (i_reg.addr)
        e3tx_pkg::TFC_OFS: st_nxt.rdata = st_r.tfc;
        e3tx_pkg::TEI_OFS: st_nxt.rdata = st_r.tei;
        e3tx_pkg::TMA_OFS: st_nxt.rdata = st_r.tma;
        e3tx_pkg::TNG_OFS: st_nxt.rdata = st_r.tng;
        e3tx_pkg::STAT_OFS: begin
          // Live insertion and frame state
          st_nxt.rdata = {8'h00, st_r.pend_fe, st_r.pend_par, st_r.pend_rei,
                          st_r.fe_left, st_r.mf};
        end
        default: st_nxt.rdata = '0;
      endcase
    end

    // Controls in force: new snapshot at frame start, held otherwise
    first = i_pay.valid && (st_r.pos == e3tx_pkg::POS_FA1);
    c_tfc = first ? st_r.tfc : st_r.s_tfc;
    c_tei = first ? st_r.tei : st_r.s_tei;
    c_tma = first ? st_r.tma : st_r.s_tma;
    c_tng = first ? st_r.tng : st_r.s_tng;
    if (first) begin
      st_nxt.s_tfc = st_r.tfc;
      st_nxt.s_tei = st_r.tei;
      st_nxt.s_tma = st_r.tma;
      st_nxt.s_tng = st_r.tng;
    end
    fgd = c_tfc[e3tx_pkg::FGD_BIT];
    nr_src = nr_src_sel_t'(c_tfc[e3tx_pkg::NR_SRC_LSB +: 2]);

    // Trigger source and its rising edge; live bits so a switch acts at once
    trig = st_r.tei[e3tx_pkg::TRIG_SEL_BIT] ? ext_s : st_r.tei[e3tx_pkg::SE_REQ_BIT];
    st_nxt.trig_d = trig;
    edge_up = trig && !st_r.trig_d;

    // Enables in force for this frame
    rei_en = c_tei[e3tx_pkg::REI_EN_BIT];
    par_en = c_tei[e3tx_pkg::PAR_EN_BIT];
    fe_en = c_tei[e3tx_pkg::FE_EN_BIT];
    fe_word = c_tei[e3tx_pkg::FE_TYPE_LSB];

    // Decide insertions at this byte's opportunity
    use_rei = rei_en && (c_tei[e3tx_pkg::REI_CONT_BIT] || st_r.pend_rei);
    use_par = par_en && (c_tei[e3tx_pkg::PAR_CONT_BIT] || st_r.pend_par);
    fe_new = fe_en && (st_r.fe_left == 3'h0) && st_r.pend_fe;
    use_fe = fe_en && ((st_r.fe_left != 3'h0) || st_r.pend_fe);

    // Remote error indication caught over the frame
    st_nxt.rei_seen = st_r.rei_seen || rei_s;

    // REI and RDI sources
    rei_bit = c_tfc[e3tx_pkg::REI_DEF_BIT] ? c_tfc[e3tx_pkg::REI_MAN_BIT]
                                            : (st_r.rei_seen || rei_s);
    rdi_bit = c_tfc[e3tx_pkg::RDI_DEF_BIT] ? c_tfc[e3tx_pkg::RDI_MAN_BIT]
                                            : alarm_s;

    // Timing bits: multiframe position plus one source bit, or direct
    if (c_tma[e3tx_pkg::TIMING_IND_GEN_DISABLE_BIT]) begin
      ti_bits = c_tma[2:0];
    end else begin
      ti_bits = {st_r.mf, c_tma[2'(e3tx_pkg::TTI_MSB) - st_r.mf]};
    end

    // Byte formation
    if (i_pay.valid) begin
      unique case (st_r.pos)
        e3tx_pkg::POS_FA1: begin
          // Alignment byte, first half of a framing error word
          d = fgd ? i_pay.data : e3tx_pkg::FA1_VAL;
          if (use_fe) begin
            d = d ^ (fe_word ? e3tx_pkg::ALL_ONES : e3tx_pkg::ONE_BIT);
          end
        end
        e3tx_pkg::POS_FA2: begin
          // Second alignment byte only hit by word errors
          d = fgd ? i_pay.data : e3tx_pkg::FA2_VAL;
          if (st_r.s_tei[e3tx_pkg::FE_EN_BIT] && st_r.fe_word_act) begin
            d = d ^ e3tx_pkg::ALL_ONES;
          end
        end
        e3tx_pkg::POS_EM: begin
          // Parity of the previous frame
          d = fgd ? i_pay.data : st_r.bip_prev;
          if (use_par) begin
            d = d ^ (c_tei[e3tx_pkg::PAR_BLK_BIT] ? e3tx_pkg::ALL_ONES : e3tx_pkg::ONE_BIT);
          end
        end
        e3tx_pkg::POS_MA: begin
          // RDI, REI, payload type, timing bits, MSB first
          d = fgd ? i_pay.data
                  : {rdi_bit, rei_bit, c_tma[e3tx_pkg::PT_LSB +: 3], ti_bits};
          if (use_rei) begin
            d = d ^ e3tx_pkg::REI_POS;
          end
          st_nxt.rei_seen = rei_s;
        end
        e3tx_pkg::POS_NR: begin
          // NR source select
          unique case (nr_src)
            e3tx_pkg::NR_ONES: d = e3tx_pkg::ALL_ONES;
            e3tx_pkg::NR_HDLC: begin
              d = i_hdlc_data;
              hdlc_take = 1'b1;
            end
            e3tx_pkg::NR_FEAC: d = i_feac_data;
            e3tx_pkg::NR_REG: d = c_tng[7:0];
          endcase
        end
        e3tx_pkg::POS_GC: begin
          // GC source select; a fresh HDLC byte, not the NR one
          if (c_tfc[e3tx_pkg::GC_SRC_BIT]) begin
            d = c_tng[e3tx_pkg::GC_LSB +: 8];
          end else begin
            d = i_hdlc_data;
            hdlc_take = 1'b1;
          end
        end
        default: d = i_pay.data;
      endcase

      // AIS overrides everything
      if (c_tfc[e3tx_pkg::AIS_BIT]) begin
        d = e3tx_pkg::ALL_ONES;
      end

      st_nxt.out.valid = 1'b1;
      st_nxt.out.data = d;

      // Running parity; finished value kept for next frame's EM
      if (first) begin
        st_nxt.bip_prev = st_r.bip_acc;
        st_nxt.bip_acc = d;
        st_nxt.mf = st_r.mf + 2'h1;
      end else begin
        st_nxt.bip_acc = st_r.bip_acc ^ d;
      end

      // Byte position
      st_nxt.pos = (st_r.pos == LAST_POS) ? 10'h000 : st_r.pos + 10'h001;
    end

    // Framing error run over one or four frames
    if (i_pay.valid && st_r.pos == e3tx_pkg::POS_FA1) begin
      st_nxt.fe_word_act = use_fe && fe_word;
      if (!fe_en) begin
        st_nxt.fe_left = 3'h0;
      end else if (st_r.fe_left != 3'h0) begin
        st_nxt.fe_left = st_r.fe_left - 3'h1;
      end else if (fe_new) begin
        st_nxt.fe_left = c_tei[e3tx_pkg::FE_TYPE_LSB + 1] ? e3tx_pkg::FE_MULTI_LEFT : 3'h0;
      end
    end

    // Pending single errors: consumed at the opportunity, new edge wins
    st_nxt.pend_rei = st_r.pend_rei && !(i_pay.valid && st_r.pos == e3tx_pkg::POS_MA && rei_en);
    st_nxt.pend_par = st_r.pend_par && !(i_pay.valid && st_r.pos == e3tx_pkg::POS_EM && par_en);
    st_nxt.pend_fe = st_r.pend_fe && !(i_pay.valid && st_r.pos == e3tx_pkg::POS_FA1 && fe_new);
    if (edge_up) begin
      st_nxt.pend_rei = st_nxt.pend_rei || st_r.tei[e3tx_pkg::REI_EN_BIT];
      st_nxt.pend_par = st_nxt.pend_par || st_r.tei[e3tx_pkg::PAR_EN_BIT];
      st_nxt.pend_fe = st_nxt.pend_fe || st_r.tei[e3tx_pkg::FE_EN_BIT];
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign o_rdata = st_r.rdata;
  assign o_line = st_r.out;
  assign o_hdlc_take = hdlc_take;
endmodule

// [e3tx_far_end.sv]
// Far-end model: transmit HDLC byte source and FEAC byte source
`timescale 1ns/1ps
module e3tx_far_end #(
  parameter logic [7:0] FEAC_BYTE = 8'h81
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // HDLC byte taken this cycle
  input wire logic i_take,
  // Byte sources
  output logic [7:0] o_hdlc_data,
  output logic [7:0] o_feac_data
);
  // Offer a fresh HDLC byte after every take
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_hdlc_data <= 8'h10;
    end else if (i_take) begin
      o_hdlc_data <= o_hdlc_data + 8'h01;
    end
  end
  // FEAC code held steady
  assign o_feac_data = FEAC_BYTE;
endmodule

// [e3tx_overhead_chk.sv]
// Port-level assertions for the E3 transmit overhead block
`timescale 1ns/1ps
module e3tx_overhead_chk #(
  parameter int FRAME_BYTES = 537
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register port
  input wire e3tx_pkg::reg_req_s i_reg,
  input wire logic [e3tx_pkg::DATA_W-1:0] o_rdata,
  // Streams
  input wire e3tx_pkg::byte_s i_pay,
  input wire e3tx_pkg::byte_s o_line,
  // HDLC source
  input wire logic [7:0] i_hdlc_data,
  input wire logic o_hdlc_take
);
  // Input byte position and register shadows
  logic [9:0] pos_r;
  logic [15:0] tng_r;
  logic [15:0] tfc_r;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pos_r <= 10'h000;
      tng_r <= 16'h0000;
      tfc_r <= 16'h0000;
    end else begin
      if (i_pay.valid) begin
        pos_r <= (pos_r == 10'(FRAME_BYTES - 1)) ? 10'h000 : pos_r + 10'h001;
      end
      if (i_reg.wr && i_reg.addr == e3tx_pkg::TNG_OFS) begin
        tng_r <= i_reg.wdata;
      end
      if (i_reg.wr && i_reg.addr == e3tx_pkg::TFC_OFS) begin
        tfc_r <= i_reg.wdata & e3tx_pkg::TFC_MASK;
      end
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_rdata_idle: assert property (!$past(i_reg.rd) |-> o_rdata == 16'h0000)
    else $error("read data not idle");
  a_tng_read: assert property (i_reg.rd && i_reg.addr == e3tx_pkg::TNG_OFS |=> o_rdata == tng_r)
    else $error("nr gc register read wrong");
  a_tfc_read: assert property (i_reg.rd && i_reg.addr == e3tx_pkg::TFC_OFS |=> o_rdata == tfc_r)
    else $error("frame control read wrong");
  a_unmapped_zero: assert property (i_reg.rd && i_reg.addr < e3tx_pkg::STAT_OFS |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_line_valid: assert property (i_pay.valid |=> o_line.valid)
    else $error("output byte missing");
  a_line_gap: assert property (!i_pay.valid |=> !o_line.valid)
    else $error("output byte without input");
  a_take_pos: assert property (o_hdlc_take |-> i_pay.valid && (pos_r == e3tx_pkg::POS_NR || pos_r == e3tx_pkg::POS_GC))
    else $error("hdlc take outside nr gc");
  a_take_data: assert property (o_hdlc_take |=> o_line.data == $past(i_hdlc_data) || o_line.data == 8'hFF)
    else $error("hdlc byte not sent");
  a_payload_pass: assert property (i_pay.valid && pos_r > e3tx_pkg::POS_GC
    |=> o_line.data == $past(i_pay.data) || o_line.data == 8'hFF)
    else $error("payload byte altered");
endmodule

// [test_e3tx_overhead.sv]
// Self-checking bench for the E3 transmit overhead block
`timescale 1ns/1ps
module test_e3tx_overhead;
  localparam int FB = 400;
  localparam logic [9:0] TFC = e3tx_pkg::TFC_OFS;
  localparam logic [9:0] TEI = e3tx_pkg::TEI_OFS;
  localparam logic [9:0] MA = e3tx_pkg::POS_MA;
  // Stimulus
  logic i_clk = 1'b0;
  logic rst_n = 1'b0;
  e3tx_pkg::reg_req_s rq = '0;
  e3tx_pkg::byte_s pay = '{1'b0, 8'h3C};
  logic rei_in = 1'b0;
  logic alarm = 1'b0;
  logic ext = 1'b0;
  // Observed side
  logic [15:0] rdata;
  e3tx_pkg::byte_s line;
  logic take;
  logic [7:0] hdlc;
  logic [7:0] feac;
  // Monitor state and counts
  int ip = 0, op = 0, nfr = 0, cyc = 0, n_fail = 0, checks = 0;
  int c_par = 0, c_fa = 0, c_rei = 0;
  logic [7:0] ob [FB];
  logic [7:0] acc = 8'h00, bip = 8'h00, pd = 8'h00, fd = 8'h00;
  e3tx_overhead #(.FRAME_BYTES(FB)) u_e3tx_overhead (
    .i_clk(i_clk), .i_rst_n(rst_n), .i_reg(rq), .o_rdata(rdata), .i_pay(pay), .o_line(line),
    .i_hdlc_data(hdlc), .o_hdlc_take(take), .i_feac_data(feac),
    .i_remote_err_indication_in(rei_in), .i_rx_alarm(alarm), .i_ext_err_trigger_in(ext));
  e3tx_far_end u_e3tx_far_end (
    .i_clk(i_clk), .i_rst_n(rst_n), .i_take(take), .o_hdlc_data(hdlc), .o_feac_data(feac));
  initial forever #20 i_clk = ~i_clk;
  // Cut a hang short
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      results();
    end
  end
  // Payload source, output capture, parity and error counts
  always @(posedge i_clk) begin
    if (pay.valid) begin
      ip <= (ip == FB - 1) ? 0 : ip + 1;
      pay.data <= 8'((ip == FB - 1) ? 0 : ip + 1) ^ 8'h3C;
    end
    if (line.valid) begin
      ob[op] <= line.data;
      op <= (op == FB - 1) ? 0 : op + 1;
      acc <= (op == FB - 1) ? 8'h00 : acc ^ line.data;
      if (op == FB - 1) begin
        bip <= acc ^ line.data;
        nfr <= nfr + 1;
      end
      if (op == int'(e3tx_pkg::POS_EM) && line.data !== bip) begin
        c_par <= c_par + 1;
        pd <= line.data ^ bip;
      end
      if (op == 0 && line.data !== e3tx_pkg::FA1_VAL) begin
        c_fa <= c_fa + 1;
        fd <= line.data ^ e3tx_pkg::FA1_VAL;
      end
      if (op == int'(MA) && line.data[6]) c_rei <= c_rei + 1;
    end
  end
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge i_clk);
    rq <= '{a, d, 1'b1, 1'b0};
    @(posedge i_clk);
    rq.wr <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, output logic [15:0] d);
    @(posedge i_clk);
    rq <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge i_clk);
    rq.rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Wait for n frames to finish leaving the block
  task automatic frames(input int n);
    int f0;
    // Settle past the edge so a frame ending on it is not counted as new
    @(negedge i_clk);
    f0 = nfr;
    wait (nfr == f0 + n);
  endtask
  // Write, then let one full frame run on the new setting
  task automatic cfg(input logic [9:0] a, input logic [15:0] d);
    wr(a, d);
    frames(2);
  endtask
  task automatic clr;
    c_par = 0;
    c_fa = 0;
    c_rei = 0;
  endtask
  // Pulse the single-error request bit
  task automatic trig(input logic [15:0] t);
    wr(TEI, t | 16'h0002);
    wr(TEI, t);
  endtask
  task automatic t_regs;
    logic [9:0] a [4] = '{TFC, TEI, e3tx_pkg::TMA_OFS, e3tx_pkg::TNG_OFS};
    logic [15:0] m [4] = '{16'h073D, 16'h03FD, 16'h00FD, 16'hFFFD};
    logic [15:0] d;
    for (int i = 0; i < 4; i++) begin
      rd(a[i], d);
      chk("reset value", d, 16'h0000);
      wr(a[i], 16'hFFFD);
      rd(a[i], d);
      chk("read back", d, m[i]);
      wr(a[i], 16'h0000);
    end
    wr(10'h100, 16'hFFFF);
    rd(10'h100, d);
    chk("unmapped", d, 16'h0000);
    $display("t_regs done");
  endtask
  task automatic t_ma;
    wr(e3tx_pkg::TMA_OFS, 16'h00B5);
    cfg(TFC, 16'h003C);
    chk("ma manual", ob[MA], 8'hED);
    rei_in <= 1'b1;
    alarm <= 1'b1;
    cfg(TFC, 16'h0000);
    chk("ma auto", ob[MA], 8'hED);
    cfg(TFC, 16'h0014);
    chk("ma defeat", ob[MA], 8'h2D);
    rei_in <= 1'b0;
    alarm <= 1'b0;
    cfg(TFC, 16'h0000);
    $display("t_ma done");
  endtask
  task automatic t_src;
    wr(e3tx_pkg::TNG_OFS, 16'hA55A);
    cfg(TFC, 16'h0700);
    chk("gc reg", ob[e3tx_pkg::POS_GC], 8'hA5);
    chk("nr reg", ob[e3tx_pkg::POS_NR], 8'h5A);
    cfg(TFC, 16'h0400);
    chk("nr ones", ob[e3tx_pkg::POS_NR], 8'hFF);
    cfg(TFC, 16'h0600);
    chk("nr feac", ob[e3tx_pkg::POS_NR], 8'h81);
    cfg(TFC, 16'h0100);
    chk("gc hdlc", ob[e3tx_pkg::POS_GC], ob[e3tx_pkg::POS_NR] + 8'h01);
    $display("t_src done");
  endtask
  task automatic t_ais;
    cfg(TFC, 16'h0001);
    chk("ais fa1", ob[0], 8'hFF);
    chk("ais ma", ob[MA], 8'hFF);
    chk("ais pay", ob[350], 8'hFF);
    cfg(TFC, 16'h0002);
    chk("pass fa1", ob[0], 8'h3C);
    chk("pass ma", ob[MA], 8'h89);
    cfg(TFC, 16'h0003);
    chk("pass ais", ob[1], 8'hFF);
    cfg(TFC, 16'h0000);
    $display("t_ais done");
  endtask
  task automatic t_par;
    cfg(TEI, 16'h0020);
    clr();
    trig(16'h0020);
    frames(3);
    chk("par single", 16'(c_par), 16'h0001);
    chk("par bit", pd, 8'h01);
    clr();
    trig(16'h0020);
    trig(16'h0020);
    frames(3);
    chk("par toggles", 16'(c_par), 16'h0001);
    cfg(TEI, 16'h00A0);
    clr();
    trig(16'h00A0);
    frames(3);
    chk("par block", pd, 8'hFF);
    cfg(TEI, 16'h0060);
    clr();
    frames(3);
    chk("par cont", 16'(c_par), 16'h0003);
    cfg(TEI, 16'h0021);
    clr();
    trig(16'h0021);
    frames(3);
    chk("par ext sel", 16'(c_par), 16'h0000);
    $display("t_par done");
  endtask
  task automatic t_rei;
    cfg(TEI, 16'h0300);
    clr();
    frames(3);
    chk("rei cont", 16'(c_rei), 16'h0003);
    cfg(TEI, 16'h0101);
    clr();
    ext <= 1'b1;
    repeat (6) @(posedge i_clk);
    ext <= 1'b0;
    frames(3);
    chk("rei ext", 16'(c_rei), 16'h0001);
    $display("t_rei done");
  endtask
  task automatic t_fe;
    for (int t = 0; t < 4; t++) begin
      cfg(TEI, 16'(4 + 8 * t));
      clr();
      trig(16'(4 + 8 * t));
      frames(6);
      chk("fe frames", 16'(c_fa), t[1] ? 16'h0004 : 16'h0001);
      chk("fe pattern", fd, t[0] ? 8'hFF : 8'h01);
    end
    cfg(TEI, 16'h0000);
    clr();
    trig(16'h0000);
    frames(2);
    chk("fe off", 16'(c_fa), 16'h0000);
    $display("t_fe done");
  endtask
  task automatic results;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge i_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    pay.valid <= 1'b1;
    frames(1);
    t_regs();
    t_ma();
    t_src();
    t_ais();
    t_par();
    t_rei();
    t_fe();
    results();
  end
endmodule
bind e3tx_overhead e3tx_overhead_chk #(.FRAME_BYTES(FRAME_BYTES)) u_e3tx_overhead_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg(i_reg), .o_rdata(o_rdata), .i_pay(i_pay),
  .o_line(o_line), .i_hdlc_data(i_hdlc_data), .o_hdlc_take(o_hdlc_take));
